//--- tmr_pkg.sv
package tmr_pkg;
  // ==========================================================
  // Register map
  localparam logic [7:0] ADDR_TIMER_CTRL = 8'h88;
  localparam logic [7:0] ADDR_TIMER_MODE = 8'h89;
  localparam logic [7:0] ADDR_C0_LOW = 8'h8a;
  localparam logic [7:0] ADDR_C1_LOW = 8'h8b;
  localparam logic [7:0] ADDR_C0_HIGH = 8'h8c;
  localparam logic [7:0] ADDR_C1_HIGH = 8'h8d;
  localparam logic [7:0] ADDR_CLOCK_CTRL = 8'h8e;
  localparam logic [7:0] ADDR_IRQ_STATUS = 8'h98;
  localparam logic [7:0] ADDR_IRQ_CLEAR = 8'h99;
  localparam logic [7:0] ADDR_IRQ_ENABLE = 8'h9a;

  // ==========================================================
  // Field positions and reset values
  localparam int unsigned OV1_BIT = 7;
  localparam int unsigned RUN1_BIT = 6;
  localparam int unsigned OV0_BIT = 5;
  localparam int unsigned RUN0_BIT = 4;
  localparam int unsigned EF1_BIT = 3;
  localparam int unsigned ET1_BIT = 2;
  localparam int unsigned EF0_BIT = 1;
  localparam int unsigned ET0_BIT = 0;
  localparam int unsigned CLK_SEL_ONE_BIT = 4;
  localparam int unsigned CLK_SEL_ZERO_BIT = 3;
  localparam logic [7:0] CLK_CTRL_MASK = 8'h18;
  localparam int unsigned IRQ_OV0 = 0;
  localparam int unsigned IRQ_EF0 = 1;
  localparam int unsigned IRQ_OV1 = 2;
  localparam int unsigned IRQ_EF1 = 3;
  localparam logic [7:0] BYTE_RESET = 8'h00;
  localparam logic [3:0] IRQ_RESET = 4'h0;

  // ==========================================================
  // Timing
  localparam int unsigned SYS_CLK_HZ = 50_000_000;
  localparam int unsigned INTERNAL_DIV = 12;

  // ==========================================================
  // Types
  typedef enum logic [1:0] {
    MODE_13BIT = 2'b00,
    MODE_16BIT = 2'b01,
    MODE_RELOAD = 2'b10,
    MODE_SPLIT = 2'b11
  } tmr_mode_t;

  typedef struct packed {
    logic gate;
    logic ct_sel;
    tmr_mode_t mode;
  } tmr_cfg_t;

  typedef struct packed {
    logic [7:0] hi;
    logic [7:0] lo;
    logic ovf;
  } count_step_t;

  typedef struct packed {
    logic tmr_one;
    logic ext_one;
    logic tmr_zero;
    logic ext_zero;
  } isr_ack_t;

  // One increment of a timer in modes 0..2; mode 3 leaves it untouched
  function automatic count_step_t count_step(input tmr_mode_t mode, input logic [7:0] hi, input logic [7:0] lo);
    count_step_t r;
    logic [13:0] s13;
    logic [16:0] s16;
    logic [8:0] s8;
    s13 = {1'b0, hi, lo[4:0]} + 14'h0001;
    s16 = {1'b0, hi, lo} + 17'h00001;
    s8 = {1'b0, lo} + 9'h001;
    r.hi = hi;
    r.lo = lo;
    r.ovf = 1'b0;
    case (mode)
      MODE_13BIT: begin
        r.hi = s13[12:5];
        r.lo = {lo[7:5], s13[4:0]};
        r.ovf = s13[13];
      end
      MODE_16BIT: begin
        r.hi = s16[15:8];
        r.lo = s16[7:0];
        r.ovf = s16[16];
      end
      MODE_RELOAD: begin
        r.lo = s8[8] ? hi : s8[7:0];
        r.ovf = s8[8];
      end
      default: begin
        r.ovf = 1'b0;
      end
    endcase
    return r;
  endfunction
endpackage

//--- count_source.sv
`timescale 1ns/1ps
`default_nettype none
module count_source (
  input wire logic mclk_i,
  input wire logic rst_n_i,
  input wire logic div_tick_i,
  input wire logic clk_sel_i,
  input wire logic ct_sel_i,
  input wire logic count_pin_i,
  output logic internal_tick_o,
  output logic tick_o
);
  logic pin_prev;

  // Idle high so a pin held low out of reset counts as one falling edge
  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      pin_prev <= 1'b1;
    end else begin
      pin_prev <= count_pin_i;
    end
  end

  assign internal_tick_o = clk_sel_i | div_tick_i; // RULE14
  assign tick_o = ct_sel_i ? (pin_prev & ~count_pin_i) : internal_tick_o; // RULE7
endmodule
`default_nettype wire

//--- ext_irq_detect.sv
`timescale 1ns/1ps
`default_nettype none
module ext_irq_detect (
  input wire logic mclk_i,
  input wire logic rst_n_i,
  input wire logic pin_i,
  input wire logic edge_type_i,
  input wire logic wr_en_i,
  input wire logic wr_val_i,
  input wire logic isr_clr_i,
  output logic flag_o,
  output logic set_o
);
  logic pin_prev;
  logic next_flag;
  wire fall = pin_prev & ~pin_i;

  assign set_o = edge_type_i ? (fall & ~flag_o) : (~pin_i & ~flag_o);

  // ==========================================================
  // Flag update, detection beats any clear in the same cycle
  always_comb begin
    if (!edge_type_i) begin
      next_flag = ~pin_i; // RULE4 RULE5
    end else if (fall) begin
      next_flag = 1'b1; // RULE3 RULE5
    end else if (isr_clr_i) begin
      next_flag = 1'b0; // RULE3
    end else if (wr_en_i) begin
      next_flag = wr_val_i;
    end else begin
      next_flag = flag_o;
    end
  end

  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      pin_prev <= 1'b1;
      flag_o <= 1'b0;
    end else begin
      pin_prev <= pin_i;
      flag_o <= next_flag;
    end
  end
endmodule
`default_nettype wire

//--- dual_timer_counter.sv
`timescale 1ns/1ps
`default_nettype none
// What this block does
// RULE1: Overflow sets a timer's flag; ISR entry clears it; software may write it.
// RULE2: Run bit enables a timer; clearing it freezes both count bytes.
// RULE3: Edge mode: falling edge sets external flag until software or ISR clears it.
// RULE4: Level mode: external flag mirrors the inverted pin; software writes ignored.
// RULE5: Trigger-type bit: 0 selects low level, 1 selects falling edge.
// RULE6: Gate 0 counts on run alone; gate 1 also needs the interrupt pin high.
// RULE7: Counter select 0 uses internal clock; 1 counts count-pin falling edges.
// RULE8: Mode 00 is 13-bit, 01 is 16-bit, 10 is 8-bit auto-reload from high byte.
// RULE9: Second timer in mode 11 stops and holds its count.
// RULE10: First timer in mode 11 splits into two independent 8-bit timers.
// RULE11: Mode register upper nibble configures second timer, lower nibble the first.
// RULE12: First timer low byte is read/write and resets to zero.
// RULE13: Control register bits can each be written on their own.
// RULE14: Internal clock is system clock over 12, or undivided when select is 1.
// RULE15: Auto-reload overflow loads low byte from high byte and sets the flag.
// RULE16: 13-bit count is high byte plus low five bits; wrap to zero sets flag.
// RULE17: In split mode the high-byte timer takes second timer run and overflow flag.
module dual_timer_counter (
  input wire logic mclk_i,
  input wire logic nrst_i,
  input wire logic [7:0] reg_addr_i,
  input wire logic [7:0] reg_wdata_i,
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  input wire logic ctrl_bit_wr_i,
  input wire logic [2:0] ctrl_bit_sel_i,
  input wire logic ctrl_bit_val_i,
  input wire tmr_pkg::isr_ack_t isr_enter_i,
  input wire logic ext_irq_zero_pin_i,
  input wire logic ext_irq_one_pin_i,
  input wire logic count_pin_zero_i,
  input wire logic count_pin_one_i,
  output logic [7:0] reg_rdata_o,
  output tmr_pkg::isr_ack_t ctrl_flags_o,
  output logic irq_o
);
  import tmr_pkg::*;

  // ==========================================================
  // Reset release
  logic rst_meta;
  logic rst_n;

  always_ff @(posedge mclk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      rst_meta <= 1'b0;
      rst_n <= 1'b0;
    end else begin
      rst_meta <= 1'b1;
      rst_n <= rst_meta;
    end
  end

  // ==========================================================
  // Registers
  logic tmr_one_overflow_flag;
  logic tmr_one_run;
  logic tmr_zero_overflow_flag;
  logic tmr_zero_run;
  logic ext_irq_one_type;
  logic ext_irq_zero_type;
  logic ext_irq_one_flag;
  logic ext_irq_zero_flag;
  logic [7:0] timer_mode;

  // No snapshot: a running timer's two bytes can tear when read
  logic [7:0] timer_zero_count_low;
  logic [7:0] timer_zero_count_high;
  logic [7:0] timer_one_count_low;
  logic [7:0] timer_one_count_high;
  logic [7:0] clock_ctrl;

  logic [3:0] irq_status;
  logic [3:0] irq_enable;

  logic [3:0] div_cnt;
  logic div_tick;

  // ==========================================================
  // Bus decode
  wire wr_ctrl = reg_wr_i && (reg_addr_i == ADDR_TIMER_CTRL);
  wire wr_mode = reg_wr_i && (reg_addr_i == ADDR_TIMER_MODE);

  wire wr_t0l = reg_wr_i && (reg_addr_i == ADDR_C0_LOW);
  wire wr_t0h = reg_wr_i && (reg_addr_i == ADDR_C0_HIGH);
  wire wr_t1l = reg_wr_i && (reg_addr_i == ADDR_C1_LOW);
  wire wr_t1h = reg_wr_i && (reg_addr_i == ADDR_C1_HIGH);
  wire wr_clk = reg_wr_i && (reg_addr_i == ADDR_CLOCK_CTRL);
  wire wr_iclr = reg_wr_i && (reg_addr_i == ADDR_IRQ_CLEAR);
  wire wr_ien = reg_wr_i && (reg_addr_i == ADDR_IRQ_ENABLE);

  // Whole-byte writes and single-bit writes share one per-bit enable
  wire [7:0] ctrl_we = wr_ctrl ? 8'hff : (ctrl_bit_wr_i ? (8'h01 << ctrl_bit_sel_i) : 8'h00); // RULE13
  wire [7:0] ctrl_wv = wr_ctrl ? reg_wdata_i : {8{ctrl_bit_val_i}}; // RULE13

  wire [7:0] ctrl_rd = {tmr_one_overflow_flag, tmr_one_run, tmr_zero_overflow_flag, tmr_zero_run,
                        ext_irq_one_flag, ext_irq_one_type, ext_irq_zero_flag, ext_irq_zero_type};

  logic [7:0] rd_mux;
  always_comb begin
    case (reg_addr_i)
      ADDR_TIMER_CTRL: rd_mux = ctrl_rd;
      ADDR_TIMER_MODE: rd_mux = timer_mode;
      ADDR_C0_LOW: rd_mux = timer_zero_count_low; // RULE12
      ADDR_C0_HIGH: rd_mux = timer_zero_count_high;
      ADDR_C1_LOW: rd_mux = timer_one_count_low;
      ADDR_C1_HIGH: rd_mux = timer_one_count_high;
      ADDR_CLOCK_CTRL: rd_mux = clock_ctrl;
      ADDR_IRQ_STATUS: rd_mux = {4'h0, irq_status};
      ADDR_IRQ_ENABLE: rd_mux = {4'h0, irq_enable};
      default: rd_mux = 8'h00;
    endcase
  end

  // ==========================================================
  // Divide-by-12 prescaler shared by both timers
  always_ff @(posedge mclk_i or negedge rst_n) begin
    if (!rst_n) begin
      div_cnt <= 4'h0;
      div_tick <= 1'b0;
    end else begin
      div_tick <= (div_cnt == 4'(INTERNAL_DIV - 1)); // RULE14
      div_cnt <= (div_cnt == 4'(INTERNAL_DIV - 1)) ? 4'h0 : div_cnt + 4'h1;
    end
  end

  // ==========================================================
  // Timer configuration and clock sources
  wire tmr_cfg_t cfg_one = tmr_cfg_t'(timer_mode[7:4]); // RULE11
  wire tmr_cfg_t cfg_zero = tmr_cfg_t'(timer_mode[3:0]); // RULE11
  wire split = (cfg_zero.mode == MODE_SPLIT);
  logic tick_zero;
  logic tick_one;
  logic int_tick_zero;

  count_source u_src_zero (
    .mclk_i(mclk_i),
    .rst_n_i(rst_n),
    .div_tick_i(div_tick),
    .clk_sel_i(clock_ctrl[CLK_SEL_ZERO_BIT]),
    .ct_sel_i(cfg_zero.ct_sel),
    .count_pin_i(count_pin_zero_i),
    .internal_tick_o(int_tick_zero),
    .tick_o(tick_zero)
  );

  count_source u_src_one (
    .mclk_i(mclk_i),
    .rst_n_i(rst_n),
    .div_tick_i(div_tick),
    .clk_sel_i(clock_ctrl[CLK_SEL_ONE_BIT]),
    .ct_sel_i(cfg_one.ct_sel),
    .count_pin_i(count_pin_one_i),
    .internal_tick_o(),
    .tick_o(tick_one)
  );

  // Gate lets an external pulse width be measured by holding the pin high
  wire en_zero = tmr_zero_run & (~cfg_zero.gate | ext_irq_zero_pin_i) & tick_zero; // RULE2 RULE6
  wire en_one = tmr_one_run & (~cfg_one.gate | ext_irq_one_pin_i) & tick_one; // RULE2 RULE6
  // Split high byte is a pure timer: internal clock, run bit of the second timer
  wire en_high_split = split & tmr_one_run & int_tick_zero; // RULE10 RULE17

  wire count_step_t step_zero = count_step(cfg_zero.mode, timer_zero_count_high, timer_zero_count_low); // RULE8
  wire count_step_t step_one = count_step(cfg_one.mode, timer_one_count_high, timer_one_count_low); // RULE8 RULE9

  wire ovf_zero = en_zero & (split ? (&timer_zero_count_low) : step_zero.ovf); // RULE10 RULE16 RULE15
  wire ovf_high_split = en_high_split & (&timer_zero_count_high); // RULE17
  // Second timer still counts under split mode but raises no flag
  wire ovf_one = (en_one & step_one.ovf & ~split) | ovf_high_split; // RULE17

  // ==========================================================
  // Count updates; a software write wins over a count in that cycle
  logic [7:0] next_t0l;
  logic [7:0] next_t0h;
  logic [7:0] next_t1l;
  logic [7:0] next_t1h;

  always_comb begin
    next_t0l = timer_zero_count_low;
    next_t0h = timer_zero_count_high;
    next_t1l = timer_one_count_low;
    next_t1h = timer_one_count_high;
    if (en_zero) begin
      next_t0l = split ? timer_zero_count_low + 8'h01 : step_zero.lo; // RULE10 RULE15
      next_t0h = split ? timer_zero_count_high : step_zero.hi; // RULE16
    end

    if (en_high_split) begin
      next_t0h = timer_zero_count_high + 8'h01; // RULE10
    end
    if (en_one) begin
      next_t1l = step_one.lo; // RULE8 RULE9
      next_t1h = step_one.hi;
    end

    if (wr_t0l) next_t0l = reg_wdata_i; // RULE12
    if (wr_t0h) next_t0h = reg_wdata_i;
    if (wr_t1l) next_t1l = reg_wdata_i;
    if (wr_t1h) next_t1h = reg_wdata_i;
  end

  // ==========================================================
  // Overflow flags: hardware set wins over any clear
  // Software may set a flag; that raises no status event
  wire next_ov0 = ovf_zero ? 1'b1 : isr_enter_i.tmr_zero ? 1'b0 :
                  ctrl_we[OV0_BIT] ? ctrl_wv[OV0_BIT] : tmr_zero_overflow_flag; // RULE1
  wire next_ov1 = ovf_one ? 1'b1 : isr_enter_i.tmr_one ? 1'b0 :
                  ctrl_we[OV1_BIT] ? ctrl_wv[OV1_BIT] : tmr_one_overflow_flag; // RULE1

  // ==========================================================
  // External interrupt flags
  logic ie_zero_set;
  logic ie_one_set;

  ext_irq_detect u_ext_zero (
    .mclk_i(mclk_i),
    .rst_n_i(rst_n),
    .pin_i(ext_irq_zero_pin_i),
    .edge_type_i(ext_irq_zero_type),
    .wr_en_i(ctrl_we[EF0_BIT]),
    .wr_val_i(ctrl_wv[EF0_BIT]),
    .isr_clr_i(isr_enter_i.ext_zero),
    .flag_o(ext_irq_zero_flag),
    .set_o(ie_zero_set)
  );

  ext_irq_detect u_ext_one (
    .mclk_i(mclk_i),
    .rst_n_i(rst_n),
    .pin_i(ext_irq_one_pin_i),
    .edge_type_i(ext_irq_one_type),
    .wr_en_i(ctrl_we[EF1_BIT]),
    .wr_val_i(ctrl_wv[EF1_BIT]),
    .isr_clr_i(isr_enter_i.ext_one),
    .flag_o(ext_irq_one_flag),
    .set_o(ie_one_set)
  );

  // ==========================================================
  // Sticky event status; a new event beats a clear in the same cycle
  logic [3:0] events;
  always_comb begin
    events = 4'h0;
    events[IRQ_OV0] = ovf_zero;
    // Level mode reports only the flag's rise
    events[IRQ_EF0] = ie_zero_set;
    events[IRQ_OV1] = ovf_one;
    events[IRQ_EF1] = ie_one_set;
  end
  wire [3:0] next_status = (irq_status & ~(wr_iclr ? reg_wdata_i[3:0] : 4'h0)) | events;

  // ==========================================================
  // State
  always_ff @(posedge mclk_i or negedge rst_n) begin
    if (!rst_n) begin
      tmr_one_overflow_flag <= 1'b0;
      tmr_one_run <= 1'b0;
      tmr_zero_overflow_flag <= 1'b0;
      tmr_zero_run <= 1'b0;
      ext_irq_one_type <= 1'b0;
      ext_irq_zero_type <= 1'b0;
      timer_mode <= BYTE_RESET;
      timer_zero_count_low <= BYTE_RESET; // RULE12
      timer_zero_count_high <= BYTE_RESET;
      timer_one_count_low <= BYTE_RESET;
      timer_one_count_high <= BYTE_RESET;
      clock_ctrl <= BYTE_RESET;
      irq_status <= IRQ_RESET;
      irq_enable <= IRQ_RESET;
      irq_o <= 1'b0;
      reg_rdata_o <= BYTE_RESET;
    end else begin
      tmr_one_overflow_flag <= next_ov1;
      tmr_zero_overflow_flag <= next_ov0;
      if (ctrl_we[RUN1_BIT]) tmr_one_run <= ctrl_wv[RUN1_BIT];
      if (ctrl_we[RUN0_BIT]) tmr_zero_run <= ctrl_wv[RUN0_BIT];
      if (ctrl_we[ET1_BIT]) ext_irq_one_type <= ctrl_wv[ET1_BIT];
      if (ctrl_we[ET0_BIT]) ext_irq_zero_type <= ctrl_wv[ET0_BIT];

      if (wr_mode) timer_mode <= reg_wdata_i;
      if (wr_clk) clock_ctrl <= reg_wdata_i & CLK_CTRL_MASK;
      if (wr_ien) irq_enable <= reg_wdata_i[3:0];

      timer_zero_count_low <= next_t0l;
      timer_zero_count_high <= next_t0h;
      timer_one_count_low <= next_t1l;
      timer_one_count_high <= next_t1h;
      irq_status <= next_status;
      irq_o <= |(next_status & (wr_ien ? reg_wdata_i[3:0] : irq_enable));
      reg_rdata_o <= reg_rd_i ? rd_mux : 8'h00;
    end
  end

  assign ctrl_flags_o = '{tmr_one: tmr_one_overflow_flag, ext_one: ext_irq_one_flag,
                          tmr_zero: tmr_zero_overflow_flag, ext_zero: ext_irq_zero_flag};
endmodule
`default_nettype wire

//--- tmr_props.sv
`timescale 1ns/1ps
`default_nettype none
module tmr_props (
  input wire logic mclk_i,
  input wire logic nrst_i,
  input wire logic [7:0] reg_addr_i,
  input wire logic [7:0] reg_wdata_i,
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  input wire logic ctrl_bit_wr_i,
  input wire logic [2:0] ctrl_bit_sel_i,
  input wire logic ctrl_bit_val_i,
  input wire tmr_pkg::isr_ack_t isr_enter_i,
  input wire logic ext_irq_zero_pin_i,
  input wire logic ext_irq_one_pin_i,
  input wire logic [7:0] reg_rdata_o,
  input wire tmr_pkg::isr_ack_t ctrl_flags_o,
  input wire logic irq_o
);
  import tmr_pkg::*;
  // ==========================================================
  // Shadow of software state; up masks the internal reset tail
  logic [1:0] up;
  logic s0;
  logic s1;
  logic [7:0] mode;
  wire logic wr_ctrl = reg_wr_i && reg_addr_i == ADDR_TIMER_CTRL;
  always_ff @(posedge mclk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      up <= 2'd0;
      s0 <= 1'b0;
      s1 <= 1'b0;
      mode <= 8'h00;
    end else begin
      if (up != 2'd3) up <= up + 2'd1;
      if (wr_ctrl) s0 <= reg_wdata_i[0];
      else if (ctrl_bit_wr_i && ctrl_bit_sel_i == 3'd0) s0 <= ctrl_bit_val_i;
      if (wr_ctrl) s1 <= reg_wdata_i[2];
      else if (ctrl_bit_wr_i && ctrl_bit_sel_i == 3'd2) s1 <= ctrl_bit_val_i;
      if (reg_wr_i && reg_addr_i == ADDR_TIMER_MODE) mode <= reg_wdata_i;
    end
  end
  default clocking @(posedge mclk_i); endclocking
  default disable iff (!nrst_i);
  // ==========================================================
  // Properties
  property p_rd_idle; !reg_rd_i |=> reg_rdata_o == 8'h00; endproperty
  a_rd_idle: assert property (p_rd_idle) else $error("read data not idle");
  property p_rd_mode; reg_rd_i && reg_addr_i == ADDR_TIMER_MODE |=> reg_rdata_o == $past(mode); endproperty
  a_rd_mode: assert property (p_rd_mode) else $error("mode readback wrong");
  property p_rd_ctrl;
    reg_rd_i && reg_addr_i == ADDR_TIMER_CTRL |=>
      {reg_rdata_o[7], reg_rdata_o[3], reg_rdata_o[5], reg_rdata_o[1], reg_rdata_o[2], reg_rdata_o[0]}
      == {$past(ctrl_flags_o), $past(s1), $past(s0)};
  endproperty
  a_rd_ctrl: assert property (p_rd_ctrl) else $error("control readback wrong");
  property p_lvl_zero; up == 2'd3 && !s0 |=> ctrl_flags_o.ext_zero == !$past(ext_irq_zero_pin_i); endproperty
  a_lvl_zero: assert property (p_lvl_zero) else $error("level flag zero wrong");
  property p_lvl_one; up == 2'd3 && !s1 |=> ctrl_flags_o.ext_one == !$past(ext_irq_one_pin_i); endproperty
  a_lvl_one: assert property (p_lvl_one) else $error("level flag one wrong");
  property p_edge_set; up == 2'd3 && s0 && $fell(ext_irq_zero_pin_i) |=> ctrl_flags_o.ext_zero; endproperty
  a_edge_set: assert property (p_edge_set) else $error("edge flag not set");
  property p_edge_hold;
    up == 2'd3 && s0 && ctrl_flags_o.ext_zero && !isr_enter_i.ext_zero && !ctrl_bit_wr_i && !wr_ctrl
      |=> ctrl_flags_o.ext_zero;
  endproperty
  a_edge_hold: assert property (p_edge_hold) else $error("edge flag lost");
  property p_isr_ext;
    up == 2'd3 && s0 && isr_enter_i.ext_zero && !$fell(ext_irq_zero_pin_i) && !ctrl_bit_wr_i && !wr_ctrl
      |=> !ctrl_flags_o.ext_zero;
  endproperty
  a_isr_ext: assert property (p_isr_ext) else $error("edge flag not cleared");
  property p_mask; reg_wr_i && reg_addr_i == ADDR_IRQ_ENABLE && reg_wdata_i == 8'h00 |=> !irq_o; endproperty
  a_mask: assert property (p_mask) else $error("masked interrupt still high");
endmodule
`default_nettype wire

//--- pin_model.sv
`timescale 1ns/1ps
`default_nettype none
module pin_model (
  input wire logic mclk_i,
  output logic ext_zero_o,
  output logic ext_one_o,
  output logic cnt_zero_o,
  output logic cnt_one_o
);
  // Pins idle high, as the pull-ups leave them
  initial begin
    ext_zero_o = 1'b1;
    ext_one_o = 1'b1;
    cnt_zero_o = 1'b1;
    cnt_one_o = 1'b1;
  end
  task set_ext(input int i, input logic v);
    @(posedge mclk_i);
    if (i == 0) ext_zero_o <= v;
    else ext_one_o <= v;
  endtask
  // Short and long phases alternate so both fast and slow edges are seen
  task pulses(input int i, input int n);
    for (int j = 0; j < n; j++) begin
      @(posedge mclk_i);
      if (i == 0) cnt_zero_o <= 1'b0;
      else cnt_one_o <= 1'b0;
      repeat (j % 2 ? 3 : 1) @(posedge mclk_i);
      if (i == 0) cnt_zero_o <= 1'b1;
      else cnt_one_o <= 1'b1;
      repeat (j % 2 ? 3 : 1) @(posedge mclk_i);
    end
  endtask
endmodule
`default_nettype wire

//--- tb.sv
`timescale 1ns/1ps
`default_nettype none
module tb;
  import tmr_pkg::*;
  logic mclk_i = 1'b0;
  logic nrst_i = 1'b0;
  logic [7:0] reg_addr_i = 8'h00;
  logic [7:0] reg_wdata_i = 8'h00;
  logic reg_wr_i = 1'b0;
  logic reg_rd_i = 1'b0;
  logic ctrl_bit_wr_i = 1'b0;
  logic [2:0] ctrl_bit_sel_i = 3'd0;
  logic ctrl_bit_val_i = 1'b0;
  isr_ack_t isr_enter_i = '0;
  wire logic e0, e1, c0, c1;
  logic [7:0] reg_rdata_o;
  isr_ack_t ctrl_flags_o;
  logic irq_o;
  int miscompares = 0;
  int n_tests = 0;
  always #10 mclk_i = ~mclk_i;
  dual_timer_counter dual_timer_counter_inst (.mclk_i(mclk_i), .nrst_i(nrst_i), .reg_addr_i(reg_addr_i),
    .reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i), .ctrl_bit_wr_i(ctrl_bit_wr_i),
    .ctrl_bit_sel_i(ctrl_bit_sel_i), .ctrl_bit_val_i(ctrl_bit_val_i), .isr_enter_i(isr_enter_i),
    .ext_irq_zero_pin_i(e0), .ext_irq_one_pin_i(e1), .count_pin_zero_i(c0), .count_pin_one_i(c1),
    .reg_rdata_o(reg_rdata_o), .ctrl_flags_o(ctrl_flags_o), .irq_o(irq_o));
  pin_model pin_model_inst (.mclk_i(mclk_i), .ext_zero_o(e0), .ext_one_o(e1), .cnt_zero_o(c0), .cnt_one_o(c1));
  // ==========================================================
  // Bus and compare tasks
  task check(input logic [7:0] seen, input logic [7:0] exp);
    n_tests++;
    if (seen !== exp) begin
      miscompares++;
      $display("ERROR %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask
  task final_report;
    $display("Comparisons %0d, mismatches %0d", n_tests, miscompares);
    if (miscompares == 0 && n_tests > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  task wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge mclk_i);
    reg_addr_i <= a;
    reg_wdata_i <= d;
    reg_wr_i <= 1'b1;
    @(posedge mclk_i);
    reg_wr_i <= 1'b0;
  endtask
  task rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge mclk_i);
    reg_addr_i <= a;
    reg_rd_i <= 1'b1;
    @(posedge mclk_i);
    reg_rd_i <= 1'b0;
    #1 d = reg_rdata_o;
  endtask
  task rdc(input logic [7:0] a, input logic [7:0] exp);
    logic [7:0] d;
    rd(a, d);
    check(d, exp);
  endtask
  task bitw(input logic [2:0] s, input logic v);
    @(posedge mclk_i);
    ctrl_bit_sel_i <= s;
    ctrl_bit_val_i <= v;
    ctrl_bit_wr_i <= 1'b1;
    @(posedge mclk_i);
    ctrl_bit_wr_i <= 1'b0;
  endtask
  task isr(input logic [3:0] v);
    @(posedge mclk_i);
    isr_enter_i <= isr_ack_t'(v);
    @(posedge mclk_i);
    isr_enter_i <= '0;
  endtask
  task flagc(input int b, input logic e);
    #1 check(ctrl_flags_o[b], e);
  endtask
  // ==========================================================
  // Expected count after n steps, worked out step by step
  function automatic logic [16:0] exp_cnt(input int t, input logic [1:0] m, input logic [7:0] hi,
                                          input logic [7:0] lo, input int n);
    logic ovf;
    logic [12:0] v;
    ovf = 1'b0;
    repeat (n) begin
      case (m)
        2'd0: begin
          v = {hi, lo[4:0]} + 13'd1;
          {hi, lo[4:0]} = v;
          ovf |= (v == 13'd0);
        end
        2'd1: begin
          {hi, lo} = {hi, lo} + 16'd1;
          ovf |= ({hi, lo} == 16'd0);
        end
        2'd2: begin
          ovf |= (lo == 8'hff);
          lo = (lo == 8'hff) ? hi : lo + 8'd1;
        end
        default: if (t == 0) begin
          lo = lo + 8'd1;
          ovf |= (lo == 8'd0);
        end
      endcase
    end
    return {ovf, hi, lo};
  endfunction
  // Run one timer for a window, then check bytes, hold and flag
  task do_run(input int t, input logic [3:0] cfg, input logic sel, input int k, input int p, input int n);
    logic [7:0] lo, hi, d;
    logic [16:0] e;
    lo = 8'($urandom) | 8'hd0;
    hi = (cfg[1:0] == 2'd2) ? 8'($urandom) : 8'hff;
    e = exp_cnt(t, cfg[1:0], hi, lo, n);
    wr(ADDR_TIMER_MODE, t ? {cfg, 4'h0} : {4'h0, cfg});
    wr(ADDR_CLOCK_CTRL, t ? {3'b000, sel, 4'h0} : {4'h0, sel, 3'b000});
    wr(ADDR_C0_LOW + 8'(t), lo);
    wr(ADDR_C0_HIGH + 8'(t), hi);
    bitw(t ? 3'd7 : 3'd5, 1'b0);
    bitw(t ? 3'd6 : 3'd4, 1'b1);
    if (p > 0) pin_model_inst.pulses(t, p);
    else repeat (k) @(posedge mclk_i);
    bitw(t ? 3'd6 : 3'd4, 1'b0);
    rdc(ADDR_C0_LOW + 8'(t), e[7:0]);
    rdc(ADDR_C0_HIGH + 8'(t), e[15:8]);
    rd(ADDR_TIMER_CTRL, d);
    check(d[t ? 7 : 5], e[16]);
    rdc(ADDR_C0_LOW + 8'(t), e[7:0]);
    isr(t ? 4'b1000 : 4'b0010);
    flagc(t ? 3 : 1, 1'b0);
  endtask
  // ==========================================================
  // Main sequence
  logic [7:0] regs0 [9] = '{8'h88, 8'h89, 8'h8a, 8'h8b, 8'h8c, 8'h8d, 8'h8e, 8'h98, 8'h9a};
  initial begin
    int k, w;
    logic [7:0] d;
    void'($urandom(32'h4204));
    repeat (10) @(posedge mclk_i);
    nrst_i <= 1'b1;
    repeat (3) @(posedge mclk_i);
    foreach (regs0[i]) rdc(regs0[i], 8'h00);
    for (int a = 8'h89; a <= 8'h8e; a++) begin
      d = 8'($urandom);
      wr(8'(a), d);
      rdc(8'(a), a == 8'h8e ? (d & CLK_CTRL_MASK) : d);
    end
    bitw(3'd2, 1'b1);
    rdc(ADDR_TIMER_CTRL, 8'h04);
    wr(ADDR_TIMER_CTRL, 8'ha5);
    rdc(ADDR_TIMER_CTRL, 8'ha5);
    wr(ADDR_TIMER_CTRL, 8'h00);
    for (int t = 0; t < 2; t++) begin
      for (int m = 0; m < 4; m++) begin
        k = $urandom_range(40, 0);
        do_run(t, 4'(m), 1'b1, k, 0, k + 2);
      end
    end
    do_run(0, 4'h1, 1'b0, 118, 0, 10);
    pin_model_inst.set_ext(0, 1'b0);
    do_run(0, 4'h9, 1'b1, 20, 0, 0);
    pin_model_inst.set_ext(0, 1'b1);
    do_run(0, 4'h9, 1'b1, 20, 0, 22);
    do_run(1, 4'h5, 1'b1, 0, 5, 5);
    do_run(0, 4'h4, 1'b0, 0, 4, 4);
    wr(ADDR_TIMER_MODE, 8'h03);
    wr(ADDR_CLOCK_CTRL, 8'h08);
    wr(ADDR_C0_HIGH, 8'hfe);
    bitw(3'd6, 1'b1);
    bitw(3'd6, 1'b0);
    rdc(ADDR_C0_HIGH, 8'h00);
    flagc(3, 1'b1);
    for (int i = 0; i < 2; i++) begin
      pin_model_inst.set_ext(i, 1'b0);
      repeat (2) @(posedge mclk_i);
      flagc(i * 2, 1'b1);
      bitw(3'(i * 2 + 1), 1'b0);
      flagc(i * 2, 1'b1);
      pin_model_inst.set_ext(i, 1'b1);
      repeat (2) @(posedge mclk_i);
      flagc(i * 2, 1'b0);
      bitw(3'(i * 2), 1'b1);
      pin_model_inst.set_ext(i, 1'b0);
      repeat (2) @(posedge mclk_i);
      flagc(i * 2, 1'b1);
      pin_model_inst.set_ext(i, 1'b1);
      repeat (2) @(posedge mclk_i);
      flagc(i * 2, 1'b1);
      bitw(3'(i * 2 + 1), 1'b0);
      flagc(i * 2, 1'b0);
      pin_model_inst.set_ext(i, 1'b0);
      repeat (2) @(posedge mclk_i);
      isr(i ? 4'b0100 : 4'b0001);
      flagc(i * 2, 1'b0);
      pin_model_inst.set_ext(i, 1'b1);
      bitw(3'(i * 2), 1'b0);
    end
    wr(ADDR_IRQ_ENABLE, 8'h00);
    wr(ADDR_IRQ_CLEAR, 8'h0f);
    rdc(ADDR_IRQ_STATUS, 8'h00);
    wr(ADDR_IRQ_ENABLE, 8'h02);
    bitw(3'd0, 1'b1);
    pin_model_inst.set_ext(0, 1'b0);
    for (w = 0; w < 20 && irq_o !== 1'b1; w++) @(posedge mclk_i) #1;
    if (w == 20) begin
      miscompares++;
      final_report();
    end
    rdc(ADDR_IRQ_STATUS, 8'h02);
    wr(ADDR_IRQ_ENABLE, 8'h00);
    #1 check(irq_o, 1'b0);
    wr(ADDR_IRQ_CLEAR, 8'h02);
    rdc(ADDR_IRQ_STATUS, 8'h00);
    rdc(ADDR_IRQ_CLEAR, 8'h00);
    rdc(8'h80, 8'h00);
    pin_model_inst.set_ext(0, 1'b1);
    bitw(3'd0, 1'b0);
    final_report();
  end
  initial begin
    repeat (100000) @(posedge mclk_i);
    miscompares++;
    final_report();
  end
endmodule
bind dual_timer_counter tmr_props tmr_props_inst (.mclk_i(mclk_i), .nrst_i(nrst_i), .reg_addr_i(reg_addr_i),
  .reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i), .ctrl_bit_wr_i(ctrl_bit_wr_i),
  .ctrl_bit_sel_i(ctrl_bit_sel_i), .ctrl_bit_val_i(ctrl_bit_val_i), .isr_enter_i(isr_enter_i),
  .ext_irq_zero_pin_i(ext_irq_zero_pin_i), .ext_irq_one_pin_i(ext_irq_one_pin_i),
  .reg_rdata_o(reg_rdata_o), .ctrl_flags_o(ctrl_flags_o), .irq_o(irq_o));
`default_nettype wire
